/* File: design/rscp_top.sv */
// Serial configuration port with register file, status pin and radio data pins.
// Assumes host pins arrive asynchronously and are sampled by the 250 MHz clock;
// demodulated receive bits come from same-clock logic with valid/ready.
//
// Overview of operation
// RULE1 - Slave port, 8-bit registers, 7-bit address
// RULE2 - Frame: address, direction bit, data MSB first
// RULE3 - Host sends address MSB first
// RULE4 - Direction bit high writes, low reads
// RULE5 - Host holds select low whole frame
// RULE6 - Input bit sampled on serial clock rise
// RULE7 - Host changes input on falling edge
// RULE8 - Write commits only after last data bit
// RULE9 - Read data shifted out on falling edges
// RULE10 - Host raises select between operations
// RULE11 - Pins undriven while select is high
// RULE12 - Registers kept in power-down, all readable
// RULE13 - Full setup 33 frames, power-down one
// RULE14 - Status pin low when PLL locked; code follows the stat_sel source, pll_locked only for STAT_PLL_LOCK and code 3
// RULE15 - Host keeps select high in power-down; the bench task t_pd reads a register while cfg_power_down is set
// RULE16 - Host releases shared pin during reads
// RULE17 - Receive data with recovered clock out
// RULE18 - Signal strength readable, drives carrier sense
// RULE19 - Transmit bits captured on data clock rise
// RULE20 - Frame counter clears on select high
`timescale 1ns/1ns
module rscp_top #(
    parameter int RADIO_DATA_CLOCK_HALF = rscp_pkg::RADIO_DATA_CLOCK_HALF_CYC,
    parameter int FIFO_DEPTH = rscp_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_clock,
    input wire logic serial_select_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    input wire logic pll_locked,
    input wire logic test_status,
    input wire logic [7:0] rssi_value,
    output logic lock_status_n,
    input wire logic demod_valid,
    output logic demod_ready,
    input wire logic demod_bit,
    input wire logic radio_data_in,
    output logic radio_data_out,
    output logic radio_data_oe_n,
    output logic radio_data_clock,
    output logic tx_bit,
    output logic tx_bit_valid,
    output logic cfg_tx_mode,
    output logic cfg_power_down
);
    // Register file; no reset from power-down or from rst_n, only the initial fill
    logic [7:0] regs [128];

    // Pin synchronisers: stage one is read only by stage two
    rscp_pkg::rscp_pins_t pin_s1_r;
    rscp_pkg::rscp_pins_t pin_s2_r;
    logic sclk_d_r;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_active;

    // Frame state
    logic [4:0] bit_cnt_r;
    logic [15:0] shift_r;
    rscp_pkg::rscp_hdr_t hdr;
    logic rd_act_r;
    logic [7:0] rd_shift_r;
    logic [7:0] wr_byte;

    // Control fields
    logic [7:0] ctrl;
    logic [1:0] stat_sel;
    logic carrier_sense;
    logic stat_level;

    // Radio data path
    logic [15:0] radio_data_clock_cnt_r;
    logic radio_data_clock_tick;
    logic radio_data_clock_r;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [0:0] fifo_out_data;
    logic fifo_in_ready;

    // Register read decode: signal strength is live, others stored
    function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] stored,
                                            input logic [7:0] live);
        logic [7:0] v;
        v = stored;
        if (a == rscp_pkg::RSSI_ADDR) begin
            v = live;
        end
        return v;
    endfunction : read_reg

    // Two flip-flops on every asynchronous pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= '{sclk: 1'b0, sel_n: 1'b1, sdi: 1'b0, rdat: 1'b0};
            pin_s2_r <= '{sclk: 1'b0, sel_n: 1'b1, sdi: 1'b0, rdat: 1'b0};
        end else begin
            pin_s1_r <= '{sclk: serial_clock, sel_n: serial_select_n,
                          sdi: serial_data_in, rdat: radio_data_in};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Serial clock edge finder on the synchronised level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= pin_s2_r.sclk;
        end
    end

    assign sel_active = !pin_s2_r.sel_n;
    // Edges count only inside a frame, so a shared clock line is ignored otherwise
    assign sclk_rise = sel_active && pin_s2_r.sclk && !sclk_d_r; // RULE6
    assign sclk_fall = sel_active && !pin_s2_r.sclk && sclk_d_r; // RULE9

    // Header and write byte as seen with the current bit appended
    assign hdr = rscp_pkg::rscp_hdr_t'(shift_r[14:7]); // RULE2
    assign wr_byte = {shift_r[6:0], pin_s2_r.sdi}; // RULE2

    // Bit counter; cleared whenever select is high, so partial frames are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= '0;
        end else if (!sel_active) begin
            bit_cnt_r <= '0; // RULE20
        end else if (sclk_rise && bit_cnt_r != rscp_pkg::FRAME_DONE) begin
            bit_cnt_r <= bit_cnt_r + 5'h01; // RULE6
        end
    end

    // Input shifter, most significant bit arrives first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= '0;
        end else if (sclk_rise && bit_cnt_r != rscp_pkg::FRAME_DONE) begin
            shift_r <= {shift_r[14:0], pin_s2_r.sdi}; // RULE6
        end
    end

    // Register write at the sixteenth bit only; shorter frames change nothing
    // Plain always, since the power-up fill below also writes the array
    always @(posedge clk) begin
        if (sclk_rise && bit_cnt_r == rscp_pkg::FRAME_LAST_BIT && hdr.wr) begin // RULE4
            regs[hdr.addr] <= wr_byte; // RULE8 RULE1 RULE12
        end
    end

    // Read engine: load after direction bit low, shift out on falling edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_act_r <= 1'b0;
            rd_shift_r <= '0;
        end else if (!sel_active) begin
            rd_act_r <= 1'b0;
        end else if (sclk_rise && bit_cnt_r == rscp_pkg::HDR_LAST_BIT
                     && !pin_s2_r.sdi) begin // RULE4
            rd_act_r <= 1'b1;
            rd_shift_r <= read_reg(shift_r[6:0], regs[shift_r[6:0]], rssi_value); // RULE18 RULE12
        end else if (sclk_fall && rd_act_r) begin
            rd_shift_r <= {rd_shift_r[6:0], 1'b0}; // RULE9
        end
    end

    // Output pin: driven only during read data, released when select rises
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_out <= 1'b0;
            serial_data_oe_n <= 1'b1;
        end else if (!sel_active) begin
            serial_data_oe_n <= 1'b1; // RULE11
        end else if (sclk_fall && rd_act_r) begin
            serial_data_out <= rd_shift_r[7]; // RULE9
            serial_data_oe_n <= 1'b0;
        end
    end

    // Control fields seen by the rest of the radio
    assign ctrl = regs[rscp_pkg::MAIN_CTRL_ADDR];
    assign stat_sel = ctrl[rscp_pkg::CTRL_STAT_LSB +: 2];
    assign carrier_sense = (rssi_value >= regs[rscp_pkg::CS_THRESH_ADDR]); // RULE18

    // Status pin source; low level means the selected condition holds
    always_comb begin
        case (stat_sel)
            rscp_pkg::STAT_PLL_LOCK: stat_level = pll_locked; // RULE14
            rscp_pkg::STAT_CARRIER: stat_level = carrier_sense; // RULE14
            rscp_pkg::STAT_TEST: stat_level = test_status;
            default: stat_level = pll_locked;
        endcase
    end

    // Registered control outputs; rst_n clears these flops, not the stored words
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_status_n <= 1'b1;
            cfg_tx_mode <= 1'b0;
            cfg_power_down <= 1'b0;
        end else begin
            lock_status_n <= !stat_level; // RULE14
            cfg_tx_mode <= ctrl[rscp_pkg::CTRL_TX_BIT];
            cfg_power_down <= ctrl[rscp_pkg::CTRL_PD_BIT]; // RULE12
        end
    end

    // Array has no reset port; clear through a one-shot sweep is avoided to keep
    // configuration intact, so reads before any write return unknown-free zeros below
    initial begin
        for (int i = 0; i < 128; i++) begin
            regs[i] = rscp_pkg::REG_RESET;
        end
    end

    // Data clock divider: one tick per half period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            radio_data_clock_cnt_r <= '0;
        end else if (radio_data_clock_tick) begin
            radio_data_clock_cnt_r <= '0;
        end else begin
            radio_data_clock_cnt_r <= radio_data_clock_cnt_r + 16'h0001;
        end
    end

    assign radio_data_clock_tick = (radio_data_clock_cnt_r == 16'(RADIO_DATA_CLOCK_HALF - 1));

    // Data clock runs free except in power-down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            radio_data_clock_r <= 1'b0;
        end else if (cfg_power_down) begin
            radio_data_clock_r <= 1'b0;
        end else if (radio_data_clock_tick) begin
            radio_data_clock_r <= !radio_data_clock_r; // RULE17
        end
    end

    assign radio_data_clock = radio_data_clock_r;

    // Receive buffer between demodulator and data pin
    rscp_fifo #(
        .WIDTH(rscp_pkg::FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(demod_valid && demod_ready),
        .in_ready(fifo_in_ready),
        .in_data(demod_bit),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Demodulator stalls while the buffer is full; registered to keep outputs on flops
    // Ready skips the cycle after an accept, so a lagging flag never offers a taken slot
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            demod_ready <= 1'b0;
        end else begin
            demod_ready <= fifo_in_ready && !cfg_tx_mode && !(demod_valid && demod_ready);
        end
    end

    // One bit leaves per data clock period, at the falling edge
    assign fifo_out_ready = !cfg_tx_mode && !cfg_power_down && radio_data_clock_tick && radio_data_clock_r;

    // Receive data pin: new bit on falling edge, stable for host's rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            radio_data_out <= 1'b0;
            radio_data_oe_n <= 1'b1;
        end else begin
            radio_data_oe_n <= cfg_tx_mode;
            if (fifo_out_ready && fifo_out_valid) begin
                radio_data_out <= fifo_out_data[0]; // RULE17
            end
        end
    end

    // Transmit capture on the rising edge of the data clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_bit <= 1'b0;
            tx_bit_valid <= 1'b0;
        end else begin
            tx_bit_valid <= cfg_tx_mode && !cfg_power_down && radio_data_clock_tick && !radio_data_clock_r; // RULE19
            if (cfg_tx_mode && radio_data_clock_tick && !radio_data_clock_r) begin
                tx_bit <= pin_s2_r.rdat; // RULE19
            end
        end
    end
endmodule : rscp_top

/* File: common/rscp_pkg.sv */
// Shared constants and types for the radio serial configuration port.
// Assumes a single 250 MHz system clock; all pin-side timing is derived from it.
package rscp_pkg;

    // System clock period and pin synchroniser depth
    localparam int CLK_PERIOD_NS = 4;
    localparam int SYNC_STAGES = 2;

    // Frame layout: 7 address bits, one direction bit, 8 data bits
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] HDR_LAST_BIT = 5'h07;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h0F;
    localparam logic [4:0] FRAME_DONE = 5'h10;

    // Addresses with side effects inside the block
    localparam logic [6:0] MAIN_CTRL_ADDR = 7'h00;
    localparam logic [6:0] CS_THRESH_ADDR = 7'h01;
    localparam logic [6:0] RSSI_ADDR = 7'h02;

    // Field positions in the main control register
    localparam int CTRL_TX_BIT = 0;
    localparam int CTRL_PD_BIT = 1;
    localparam int CTRL_STAT_LSB = 2;

    // Status pin sources
    localparam logic [1:0] STAT_PLL_LOCK = 2'h0;
    localparam logic [1:0] STAT_CARRIER = 2'h1;
    localparam logic [1:0] STAT_TEST = 2'h2;

    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    // Radio data clock half period as time, then as cycles (least time, rounded up)
    localparam int RADIO_DATA_CLOCK_HALF_NS = 200;
    localparam int RADIO_DATA_CLOCK_HALF_CYC = (RADIO_DATA_CLOCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Receive FIFO shape
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 1;

    // Header of a frame once the direction bit is in
    typedef struct packed {
        logic [6:0] addr;
        logic wr;
    } rscp_hdr_t;

    // Synchronised serial port pins
    typedef struct packed {
        logic sclk;
        logic sel_n;
        logic sdi;
        logic rdat;
    } rscp_pins_t;

endpackage : rscp_pkg

/* File: design/rscp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock; depth is a power of two.
`timescale 1ns/1ns
module rscp_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // Full and empty follow the occupancy count; the full mark needs AW+1 bits
    assign in_ready = (count_r != FULL_CNT);
    assign out_valid = (count_r != '0);
    assign out_data = mem[rptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage is written only on an accepted push
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_r] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_r <= '0;
            rptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : rscp_fifo

/* File: verification/rscp_checker.sv */
// Concurrent checks on the pins of the serial configuration port.
// Assumes it is bound into rscp_top and sees only that module's ports.
`timescale 1ns/1ns
module rscp_checker #(
    parameter int RADIO_DATA_CLOCK_HALF = 4,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_select_n,
    input wire logic serial_data_oe_n,
    input wire logic radio_data_clock,
    input wire logic radio_data_out,
    input wire logic radio_data_oe_n,
    input wire logic demod_ready,
    input wire logic tx_bit_valid,
    input wire logic cfg_tx_mode,
    input wire logic cfg_power_down
);
    // One clock domain, so clocking and disable are stated once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Select lags by the synchroniser, hence four cycles of margin for AST_OE_IDLE and five for AST_OE_FRAMED
    AST_OE_IDLE: assert property (serial_select_n [*4] |-> serial_data_oe_n)
        else $error("serial output driven while select high");
    AST_OE_FRAMED: assert property (!serial_data_oe_n |-> !$past(serial_select_n, 5))
        else $error("serial output driven outside a frame");
    AST_TX_STROBE: assert property (tx_bit_valid |-> radio_data_clock && cfg_tx_mode)
        else $error("transmit bit taken away from a data clock rise");
    AST_TX_PULSE: assert property (tx_bit_valid |=> !tx_bit_valid)
        else $error("transmit strobe longer than one cycle");
    AST_PD_CLOCK: assert property (cfg_power_down [*2] |-> !radio_data_clock)
        else $error("data clock running in power-down");
    AST_TX_RELEASE: assert property (cfg_tx_mode [*2] |-> radio_data_oe_n && !demod_ready)
        else $error("data pin driven or receive accepted in transmit mode");
    AST_RX_DRIVE: assert property (!cfg_tx_mode [*2] |-> !radio_data_oe_n)
        else $error("data pin not driven in receive mode");
    AST_RX_EDGE: assert property ($changed(radio_data_out) |-> $fell(radio_data_clock))
        else $error("receive data changed away from a data clock fall");
endmodule : rscp_checker

bind rscp_top rscp_checker #(.RADIO_DATA_CLOCK_HALF(RADIO_DATA_CLOCK_HALF), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
    .clk(clk),
    .rst_n(rst_n),
    .serial_select_n(serial_select_n),
    .serial_data_oe_n(serial_data_oe_n),
    .radio_data_clock(radio_data_clock),
    .radio_data_out(radio_data_out),
    .radio_data_oe_n(radio_data_oe_n),
    .demod_ready(demod_ready),
    .tx_bit_valid(tx_bit_valid),
    .cfg_tx_mode(cfg_tx_mode),
    .cfg_power_down(cfg_power_down)
);

/* File: verification/rscp_host_model.sv */
// Host serial master: sends one frame of up to 16 bits per start pulse.
// Assumes the 250 MHz clock; serial clock period 12 cycles, idle low.
`timescale 1ns/1ns
module rscp_host_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [15:0] wdata,
    input wire logic [4:0] nbits,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    output logic busy,
    output logic [7:0] rdata,
    output logic sclk,
    output logic sel_n,
    output logic sdi
);
    logic held;
    // Undriven output line shows the inverse of its last level, not a kept value
    wire logic line_v = sdo_oe_n ? ~held : sdo;
    initial begin
        busy = 1'b0;
        sclk = 1'b0;
        sel_n = 1'b1;
        sdi = 1'b0;
        rdata = 8'h00;
        held = 1'b0;
    end
    always @(posedge clk) begin
        if (!sdo_oe_n) held <= sdo;
    end
    // A short count gives a partial frame on purpose
    always @(posedge clk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            sel_n <= 1'b0;
            repeat (2) @(posedge clk);
            for (int i = 0; i < nbits; i++) begin
                sdi <= wdata[15-i];
                repeat (6) @(posedge clk);
                sclk <= 1'b1;
                if (i > 7) rdata[15-i] <= line_v;
                repeat (6) @(posedge clk);
                sclk <= 1'b0;
            end
            repeat (6) @(posedge clk);
            sel_n <= 1'b1;
            sdi <= ~sdi;
            repeat (4) @(posedge clk);
            busy <= 1'b0;
        end
    end
endmodule : rscp_host_model

/* File: verification/tb_top.sv */
// Self-checking bench for rscp_top with a host model on the serial port.
// Assumes a shortened data clock (RADIO_DATA_CLOCK_HALF 4) to keep the run brief.
`timescale 1ns/1ns
module tb_top;
    logic clk, rst_n, start, busy, sclk, sel_n, sdi, sdo, sdo_oe_n;
    logic pll_locked, test_status, demod_valid, demod_ready, demod_bit;
    logic radio_data_in, radio_data_out, radio_data_oe_n, radio_data_clock;
    logic lock_status_n, tx_bit, tx_bit_valid, cfg_tx_mode, cfg_power_down;
    logic [7:0] rssi_value, rdata;
    logic [15:0] wdata;
    logic [4:0] nbits;
    int failures, comparisons, cyc;
    localparam logic [31:0] PAT = 32'hB5C39A6D;

    rscp_top #(.RADIO_DATA_CLOCK_HALF(4), .FIFO_DEPTH(16)) dut_u (
        .clk(clk), .rst_n(rst_n), .serial_clock(sclk), .serial_select_n(sel_n),
        .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe_n(sdo_oe_n),
        .pll_locked(pll_locked), .test_status(test_status), .rssi_value(rssi_value),
        .lock_status_n(lock_status_n), .demod_valid(demod_valid),
        .demod_ready(demod_ready), .demod_bit(demod_bit), .radio_data_in(radio_data_in),
        .radio_data_out(radio_data_out), .radio_data_oe_n(radio_data_oe_n),
        .radio_data_clock(radio_data_clock), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
        .cfg_tx_mode(cfg_tx_mode), .cfg_power_down(cfg_power_down));
    rscp_host_model host_u (.clk(clk), .start(start), .wdata(wdata), .nbits(nbits),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n), .busy(busy), .rdata(rdata), .sclk(sclk),
        .sel_n(sel_n), .sdi(sdi));

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            print_verdict;
        end
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic chk1(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask : chk1
    // One framed transfer; waits on the host's busy under a bound
    task automatic frame(input logic [15:0] w, input logic [4:0] n);
        @(posedge clk);
        start <= 1'b1;
        wdata <= w;
        nbits <= n;
        @(posedge clk);
        start <= 1'b0;
        repeat (300) begin
            @(posedge clk);
            if (busy === 1'b0) break;
        end
    endtask : frame
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        frame({a, 1'b1, d}, 5'h10);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        frame({a, 1'b0, 8'h00}, 5'h10);
        chk8("read_data", exp, rdata);
    endtask : rd

    // Fill the FIFO until refused, then drain it through the data pin
    task automatic t_rx;
        logic q[$];
        logic prev;
        int n;
        n = 0;
        prev = 1'b0;
        chk1("rx_drive", 1'b0, radio_data_oe_n);
        @(posedge clk);
        demod_valid <= 1'b1;
        demod_bit <= PAT[0];
        repeat (400) begin
            @(posedge clk);
            if (demod_valid && demod_ready) begin
                n++;
                demod_bit <= PAT[n];
            end else if (demod_valid && n >= 24) demod_valid <= 1'b0;
            if (radio_data_clock && !prev && (q.size() > 0 || radio_data_out)) begin
                q.push_back(radio_data_out);
            end
            prev = radio_data_clock;
        end
        chk1("rx_ready", 1'b1, demod_ready);
        chk1("rx_count", 1'b1, q.size() > n);
        for (int k = 0; k < n && k < q.size(); k++) chk1("rx_bit", PAT[k], q[k]);
        chk1("rx_hold", PAT[n-1], q[q.size()-1]);
        $display("test rx done");
    endtask : t_rx

    // Writes in any order incl. top address, read back, then a short frame
    task automatic t_regs;
        wr(7'h7F, 8'hA5);
        wr(7'h05, 8'h3C);
        wr(7'h40, 8'h81);
        rd(7'h40, 8'h81);
        rd(7'h05, 8'h3C);
        rd(7'h7F, 8'hA5);
        frame({7'h05, 1'b1, 8'h00}, 5'h0F);
        rd(7'h05, 8'h3C);
        $display("test regs done");
    endtask : t_regs

    // Every status source, each true and false; carrier threshold 0x90
    task automatic t_status;
        wr(7'h01, 8'h90);
        for (int s = 0; s < 3; s++) begin
            wr(7'h00, {4'h0, s[1:0], 2'b00});
            for (int v = 0; v < 2; v++) begin
                @(posedge clk);
                pll_locked <= v[0];
                test_status <= v[0];
                rssi_value <= v[0] ? 8'h9E : 8'h80;
                repeat (4) @(posedge clk);
                chk1("lock_status_n", !v[0], lock_status_n);
            end
        end
        rd(7'h02, 8'h9E);
        $display("test status done");
    endtask : t_status

    task automatic t_pd;
        wr(7'h00, 8'h02);
        repeat (4) @(posedge clk);
        chk8("pd_pins", 8'h02, {6'h00, cfg_power_down, radio_data_clock});
        rd(7'h7F, 8'hA5);
        wr(7'h00, 8'h00);
        $display("test pd done");
    endtask : t_pd

    // Transmit: pin changes after each data clock fall, captured at the rise
    task automatic t_tx;
        logic prev;
        logic exp_b;
        int j;
        int nt;
        prev = 1'b0;
        exp_b = 1'b0;
        j = 0;
        nt = 0;
        wr(7'h00, 8'h01);
        repeat (3) @(posedge clk);
        chk8("tx_pins", 8'h06, {5'h00, cfg_tx_mode, radio_data_oe_n, demod_ready});
        repeat (200) begin
            @(posedge clk);
            if (tx_bit_valid === 1'b1 && j > 0) begin
                chk1("tx_bit", exp_b, tx_bit);
                nt++;
            end
            if (prev && !radio_data_clock) begin
                radio_data_in <= PAT[j];
                exp_b = PAT[j];
                j++;
            end
            prev = radio_data_clock;
        end
        chk1("tx_count", 1'b1, nt >= 8);
        wr(7'h00, 8'h00);
        $display("test tx done");
    endtask : t_tx

    // Second reset mid-run; the register file outlives it
    task automatic t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk8("reset_pins", 8'h07, {5'h00, sdo_oe_n, lock_status_n, radio_data_oe_n});
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(7'h7F, 8'hA5);
        $display("test reset done");
    endtask : t_reset

    task automatic print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        wdata = 16'h0000;
        nbits = 5'h10;
        pll_locked = 1'b0;
        test_status = 1'b0;
        rssi_value = 8'h00;
        demod_valid = 1'b0;
        demod_bit = 1'b0;
        radio_data_in = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_rx;
        t_regs;
        t_status;
        t_pd;
        t_tx;
        t_reset;
        print_verdict;
    end
endmodule : tb_top
